//--- logic/bus_ctl_pkg.sv
// shared constants of the bus and interrupt control shell
// assumes a 25 MHz oscillator clock and a 32-bit APB register port
`default_nettype none
package bus_ctl_pkg;
  // ---------------------------------------------
  // clocking
  // ---------------------------------------------
  localparam int unsigned OSC_HZ = 25_000_000; // oscillator rate on clk
  localparam int unsigned PHASE_DIV = 4; // clk cycles per bus cycle
  localparam logic [1:0] PH_LAST = 2'(PHASE_DIV - 1); // last quarter of a bus cycle
  localparam logic [1:0] PH_RISE = 2'h1; // quarter that ends as phi2 rises
  localparam logic [2:0] INIT_CYCLES = 3'h6; // bus cycles of the reset sequence
  localparam logic [1:0] LOCK_CYCLES = 2'h2; // bus cycles of the rmw lock
  // ---------------------------------------------
  // vectors (low byte address)
  // ---------------------------------------------
  localparam logic [15:0] VEC_BREAK = 16'hFFFE;
  localparam logic [15:0] VEC_ROWRX = 16'hFFF8;
  localparam logic [15:0] VEC_EXT = 16'hFFFA;
  localparam logic [15:0] VEC_TIMER = 16'hFFFC;
  localparam logic [15:0] VEC_RESET = 16'hFFEE;
  localparam logic [15:0] VEC_NMI = 16'hFFEC;
  // ---------------------------------------------
  // internal address map
  // ---------------------------------------------
  localparam logic [15:0] ROM_BASE = 16'hF800; // rom spans F800..FFFF
  localparam logic [11:0] IO_PAGE = 12'h00F; // 00F0..00FF registers
  localparam logic [1:0] RAM_SLICE = 2'h3; // a7:a6 of ram window
  // ---------------------------------------------
  // apb registers
  // ---------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00; // control, read/write
  localparam logic [7:0] REG_STAT = 8'h04; // status, write 1 to bit 0 clears row/receive pending
  localparam logic [7:0] REG_CAPT = 8'h08; // captured row/receive count
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam int unsigned CB_MODE = 0; // 3-bit communication mode
  localparam int unsigned CB_TONE = 3; // square tone enable
  localparam int unsigned CB_FLOAT = 4; // bus float control
  localparam int unsigned SB_RRPEND = 0; // row/receive interrupt pending
  localparam int unsigned SB_NMIPEND = 1;
  localparam int unsigned SB_TEST = 2;
  localparam int unsigned SB_PERIPH = 3;
  localparam int unsigned SB_INIT = 4;
  // ---------------------------------------------
  // communication modes
  // ---------------------------------------------
  typedef enum logic [2:0] {
    MODE_IDLE = 3'b000, MODE_INTERVAL = 3'b001, MODE_PULSE = 3'b010,
    MODE_ROWTONE = 3'b011, MODE_COLUMN = 3'b100, MODE_MODEM = 3'b101,
    MODE_MODEM_DIV = 3'b110, MODE_DTMF = 3'b111
  } comm_mode_t;
endpackage
`default_nettype wire

//--- logic/pin_sync.sv
// two-flop synchroniser for a group of pin inputs
// assumes each bit is an independent level
`default_nettype none
module pin_sync
  import bus_ctl_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [WIDTH-1:0] pinIn, // raw pins
  input wire logic [WIDTH-1:0] idleVal, // documents the reset value; flops always reset to all ones
  output logic [WIDTH-1:0] pinSync // safe copy
);
  logic [WIDTH-1:0] stage1; // read only by stage two
  // ---------------------------------------------
  // per-bit double flop
  // ---------------------------------------------
  genvar i;
  for (i = 0; i < WIDTH; i++)
  begin : gBit
    always_ff @(posedge clk or posedge reset)
    begin
      if (reset)
      begin
        stage1[i] <= 1'b1;
        pinSync[i] <= 1'b1;
      end
      else
      begin
        stage1[i] <= pinIn[i];
        pinSync[i] <= stage1[i];
      end
    end
  end
  // idle value unused beyond documentation of the all-high reset state
  logic unusedIdle;
  assign unusedIdle = ^idleVal;
endmodule
`default_nettype wire

//--- logic/vector_select.sv
// interrupt source priority and vector address choice
// assumes one-hot-free requests; highest priority wins
`default_nettype none
module vector_select
  import bus_ctl_pkg::*;
(
  input wire logic takeReset, // reset sequence still running
  input wire logic takeNmi, // latched nmi edge
  input wire logic takeBreak, // software break
  input wire logic reqALow, // line a asserted
  input wire logic reqBLow, // line b asserted
  output logic [15:0] vector // low-byte vector address
);
  // ---------------------------------------------
  // priority chain
  // ---------------------------------------------
  assign vector = takeReset ? VEC_RESET :
                  takeNmi ? VEC_NMI :
                  takeBreak ? VEC_BREAK :
                  (reqALow && reqBLow) ? VEC_ROWRX : // [RL1]
                  reqBLow ? VEC_EXT : // [RL1]
                  VEC_TIMER; // [RL1]
endmodule
`default_nettype wire

//--- logic/mcu_bus_interrupt_control.sv
// system control shell: interrupt vectoring, reset sequence, bus pins
// assumes a cpu core on clk; ports, timers and tone dacs live elsewhere
// What this block does
// [RL1] vectors per source at fixed address pairs
// [RL2] nmi falling edge vectors to FFEC after instruction
// [RL3] held-low nmi never retriggers without edge
// [RL4] direction low: buses reversed, rw is input
// [RL5] direction high: rw drives internal read/write
// [RL6] direction low at reset: test mode, rom select high disables internal rom
// [RL7] test mode: port d bit1 mirrors rom select
// [RL8] sync high after fetch start, rest of cycle
// [RL9] ready low in phi2 low stalls, freezes bus
// [RL10] lock low exactly two rmw bus cycles
// [RL11] drive 16-bit address; float bit weakly pulls low
// [RL12] reversed: external address feeds internal decoder
// [RL13] rw high reads, low writes, floats weak low
// [RL14] peripheral read: rw high enables data out
// [RL15] square tone from counter carry, gated
// [RL16] pulse mode: carrier edges capture and interrupt
// [RL17] outside holds reset two cycles after power
// [RL18] reset: rw high, ports high, control cleared
// [RL19] six-cycle init then mask and vector FFEE
// [RL20] bus clock is oscillator divided by four
// [RL21] test mode: rom select high external, low internal
// [RL22] float bit decides whether external bus active
// [RL23] maskable lines level sensitive under mask flag
`default_nettype none
module mcu_bus_interrupt_control
  import bus_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic nmiPinN, // unmaskable request pin
  input wire logic maskable_req_a_n, // pin level of line a
  input wire logic maskable_req_b_n, // pin level of line b
  output logic maskReqAOut, // value driven on line a
  output logic maskReqAOe,
  output logic maskReqBOut,
  output logic maskReqBOe,
  input wire logic bus_direction_sel, // high: cpu owns bus
  input wire logic readyPin,
  input wire logic rwIn,
  output logic rwOut,
  output logic rwOe,
  input wire logic [15:0] addrIn,
  output logic [15:0] addrOut,
  output logic addrOe,
  input wire logic [7:0] dataIn,
  output logic [7:0] dataOut,
  output logic dataOe,
  output logic busWeakPulldown, // weak pull to ground engaged
  input wire logic outside_rom_select,
  output logic port_d_bit1,
  output logic rmw_lock_n,
  output logic syncOut,
  output logic phi2Out,
  output logic tone_square_out,
  input wire logic carrier_edge_in,
  input wire logic [15:0] coreAddr, // cpu address
  input wire logic [7:0] coreWdata,
  input wire logic coreRead, // high for a read cycle
  input wire logic coreOpFetch, // current cycle is an op fetch
  input wire logic coreInstrDone, // instruction boundary
  input wire logic coreIntMask, // interrupt mask flag
  input wire logic coreBreak, // software break pending
  input wire logic coreRmwStart, // modify cycle begins
  input wire logic [7:0] rrCount, // row/receive counter
  input wire logic rrCarry, // counter carry pulse
  input wire logic timerIrq, // timer request level
  input wire logic [7:0] intReadData, // internal memory data
  output logic phaseTick, // one pulse per bus cycle
  output logic coreHold, // stall the cpu
  output logic intTake, // vector now
  output logic [15:0] intVector,
  output logic setIntMask,
  output logic [15:0] extAddr, // peripheral access address
  output logic extWrite, // peripheral write strobe
  output logic [7:0] extWdata,
  output logic selRom,
  output logic selRam,
  output logic selIo,
  output logic [2:0] comm_mode_sel
);
  // ---------------------------------------------
  // state
  // ---------------------------------------------
  logic [1:0] phaseCnt; // quarter of bus cycle
  logic [7:0] ctrl; // control register
  logic [7:0] rrCapture; // captured count
  logic rrPend; // row/receive interrupt pending
  logic nmiPend; // nmi edge latched
  logic nmiPrev; // last sampled nmi level
  logic carrierPrev;
  logic [2:0] initCnt; // bus cycles left in init
  logic initBusy;
  logic strapTaken; // strap caught after release
  logic testMode; // test mode strap, direction low at release
  logic [1:0] lockCnt;
  logic toneFlop;
  logic stall;
  // ---------------------------------------------
  // pin synchronisers
  // ---------------------------------------------
  logic [6:0] syncIn;
  logic [6:0] syncOutV;
  logic nmiS, reqAS, reqBS, dirS, readyS, rwS, romSelS, carrS;
  assign syncIn = {nmiPinN, maskable_req_a_n, maskable_req_b_n, bus_direction_sel,
                   readyPin, rwIn, outside_rom_select};
  pin_sync #(.WIDTH(7)) uSync (
    .clk(clk),
    .reset(reset),
    .pinIn(syncIn),
    .idleVal(7'h7F),
    .pinSync(syncOutV)
  );
  assign {nmiS, reqAS, reqBS, dirS, readyS, rwS, romSelS} = syncOutV;
  logic [0:0] carrV;
  pin_sync #(.WIDTH(1)) uCarr (
    .clk(clk),
    .reset(reset),
    .pinIn(carrier_edge_in),
    .idleVal(1'h1),
    .pinSync(carrV)
  );
  assign carrS = carrV[0];
  // ---------------------------------------------
  // decode
  // ---------------------------------------------
  logic modeNormal, busFloat, toneEn, pulseMode, carrierEdge, nmiFall;
  logic apbWr, apbRd, hitCtrl, hitStat, hitCapt, hitAny, romExternal;
  logic irqWanted, takeNow;
  logic [15:0] vecSel;
  assign modeNormal = dirS;
  assign busFloat = ctrl[CB_FLOAT];
  assign toneEn = ctrl[CB_TONE];
  assign comm_mode_sel = ctrl[CB_MODE +: 3];
  assign pulseMode = (comm_mode_sel == MODE_PULSE) || (comm_mode_sel == MODE_MODEM)
                     || (comm_mode_sel == MODE_MODEM_DIV);
  assign carrierEdge = pulseMode && (carrS != carrierPrev); // [RL16]
  assign nmiFall = nmiPrev && !nmiS; // [RL2] [RL3]
  assign phaseTick = (phaseCnt == PH_LAST); // [RL20]
  assign phi2Out = phaseCnt[1];
  assign apbWr = psel && penable && pwrite;
  assign apbRd = psel && !pwrite;
  assign hitCtrl = (paddr == REG_CTRL);
  assign hitStat = (paddr == REG_STAT);
  assign hitCapt = (paddr == REG_CAPT);
  assign hitAny = hitCtrl || hitStat || hitCapt;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hitAny;
  // test mode rom choice: select pin high means outside rom
  assign romExternal = testMode && romSelS; // [RL6] [RL21]
  assign port_d_bit1 = testMode ? romExternal : 1'b1; // [RL7] [RL18]
  // level sensitive maskable lines, ignored under mask
  assign irqWanted = !coreIntMask && (!reqAS || !reqBS); // [RL23]
  assign takeNow = phaseTick && !stall && !initBusy && coreInstrDone
                   && (nmiPend || coreBreak || irqWanted);
  vector_select uVec (
    .takeReset(initBusy), // reset vector outranks all while init runs
    .takeNmi(nmiPend),
    .takeBreak(coreBreak),
    .reqALow(!reqAS),
    .reqBLow(!reqBS),
    .vector(vecSel)
  );
  // wire-or request lines pulled by internal sources
  assign maskReqAOut = 1'b0;
  assign maskReqBOut = 1'b0;
  assign maskReqAOe = rrPend || timerIrq; // [RL1]
  assign maskReqBOe = rrPend; // [RL1]
  // ---------------------------------------------
  // bus pins
  // ---------------------------------------------
  logic [15:0] decAddr;
  assign decAddr = modeNormal ? coreAddr : addrIn; // [RL12]
  assign selRom = (decAddr >= ROM_BASE) && !romExternal; // [RL6]
  assign selIo = (decAddr[15:4] == IO_PAGE);
  assign selRam = (decAddr[15:9] == '0) && (decAddr[7:6] == RAM_SLICE) && !selIo;
  assign busWeakPulldown = modeNormal && busFloat; // [RL11] [RL13]
  assign addrOe = modeNormal && !busFloat && !initBusy; // [RL11] [RL22]
  assign rwOe = modeNormal && !busFloat; // [RL5] [RL4]
  assign dataOe = modeNormal ? (!busFloat && !rwOut && phi2Out && !initBusy)
                             : rwS; // [RL14]
  assign coreHold = stall || !modeNormal; // [RL4] [RL9]
  assign extAddr = addrIn;
  assign extWdata = dataIn;
  assign extWrite = !modeNormal && !rwS && phaseTick; // [RL4]
  assign tone_square_out = toneFlop && toneEn; // [RL15]
  // ---------------------------------------------
  // bus phase divider
  // ---------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      phaseCnt <= '0;
    else
      phaseCnt <= phaseCnt + 2'h1; // [RL20]
  end
  // ---------------------------------------------
  // reset sequence and strap capture
  // ---------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      initCnt <= INIT_CYCLES;
      initBusy <= 1'b1;
      strapTaken <= 1'b0;
      testMode <= 1'b0;
    end
    else
    begin
      // strap caught once from the synced pin, at the first bus cycle end
      if (!strapTaken && phaseTick)
      begin
        strapTaken <= 1'b1;
        testMode <= !dirS; // [RL6]
      end
      if (initBusy && phaseTick)
      begin
        initCnt <= initCnt - 3'h1; // [RL19]
        if (initCnt == 3'h1)
          initBusy <= 1'b0;
      end
    end
  end
  // ---------------------------------------------
  // vector hand-off to the core
  // ---------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      intTake <= 1'b0;
      setIntMask <= 1'b0;
      intVector <= VEC_RESET;
    end
    else if (initBusy && phaseTick && initCnt == 3'h1)
    begin
      intTake <= 1'b1; // [RL19]
      setIntMask <= 1'b1;
      intVector <= VEC_RESET;
    end
    else if (takeNow)
    begin
      intTake <= 1'b1; // [RL1] [RL2]
      setIntMask <= 1'b1;
      intVector <= vecSel;
    end
    else
    begin
      intTake <= 1'b0;
      setIntMask <= 1'b0;
    end
  end
  // ---------------------------------------------
  // nmi edge latch, new edge wins over the take
  // ---------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      nmiPrev <= 1'b1;
      nmiPend <= 1'b0;
    end
    else
    begin
      nmiPrev <= nmiS;
      if (nmiFall)
        nmiPend <= 1'b1; // [RL2]
      else if (takeNow)
        nmiPend <= 1'b0; // [RL3]
    end
  end
  // ---------------------------------------------
  // ready stall at the phi2 rise
  // ---------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      stall <= 1'b0;
    else if (phaseCnt == PH_RISE && !readyS)
      stall <= 1'b1; // [RL9]
    else if (readyS)
      stall <= 1'b0; // [RL9]
  end
  // ---------------------------------------------
  // address, data and rw outputs, frozen on stall in normal mode
  // ---------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      addrOut <= '0;
      dataOut <= '0;
      rwOut <= 1'b1; // [RL18]
    end
    else if (!modeNormal)
    begin
      dataOut <= intReadData; // [RL14]
      rwOut <= 1'b1;
    end
    else if (!stall && !initBusy)
    begin
      addrOut <= coreAddr; // [RL11] [RL9]
      dataOut <= coreWdata;
      rwOut <= coreRead; // [RL13] [RL5]
    end
  end
  // ---------------------------------------------
  // sync marker and rmw lock
  // ---------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      syncOut <= 1'b0;
      lockCnt <= '0;
      rmw_lock_n <= 1'b1;
    end
    else
    begin
      // fetch flag caught as the bus cycle opens, dropped as it ends
      if (phaseCnt == '0)
        syncOut <= coreOpFetch && !initBusy; // [RL8]
      else if (phaseTick)
        syncOut <= 1'b0; // [RL8]
      if (coreRmwStart && phaseTick && !stall)
      begin
        lockCnt <= LOCK_CYCLES; // [RL10]
        rmw_lock_n <= 1'b0;
      end
      else if (phaseTick && lockCnt != '0)
      begin
        lockCnt <= lockCnt - 2'h1;
        rmw_lock_n <= (lockCnt == 2'h1); // [RL10]
      end
    end
  end
  // ---------------------------------------------
  // carrier capture, tone flop and registers
  // ---------------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      carrierPrev <= 1'b1;
      rrCapture <= '0;
      rrPend <= 1'b0;
      toneFlop <= 1'b0;
      ctrl <= CTRL_RESET; // [RL18]
    end
    else
    begin
      carrierPrev <= carrS;
      if (carrierEdge)
        rrCapture <= rrCount; // [RL16]
      // set wins over a same-cycle clear
      if (carrierEdge || (comm_mode_sel == MODE_INTERVAL && rrCarry))
        rrPend <= 1'b1; // [RL16]
      else if (apbWr && hitStat && pwdata[SB_RRPEND])
        rrPend <= 1'b0;
      if (rrCarry)
        toneFlop <= !toneFlop; // [RL15]
      if (apbWr && hitCtrl)
        ctrl <= pwdata[7:0]; // [RL22]
    end
  end
  // ---------------------------------------------
  // read mux
  // ---------------------------------------------
  logic [7:0] statWord;
  assign statWord = {3'h0, initBusy, !modeNormal, testMode, nmiPend, rrPend};
  assign prdata = !apbRd ? '0 :
                  hitCtrl ? {24'h00_0000, ctrl} :
                  hitStat ? {24'h00_0000, statWord} :
                  hitCapt ? {24'h00_0000, rrCapture} : '0;
  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  AST_NMI_VEC: assert property (takeNow && nmiPend |=> intVector == VEC_NMI && setIntMask) // [RL2]
    else $error("nmi did not vector to FFEC");
  AST_NMI_ONCE: assert property (takeNow && nmiPend && !nmiFall |=> !nmiPend) // [RL3]
    else $error("nmi retriggered without a new edge");
  AST_INIT: assert property ($fell(initBusy) |-> intTake && intVector == VEC_RESET) // [RL19]
    else $error("reset vector missing after init");
  AST_LOCK: assert property ($fell(rmw_lock_n) |-> !rmw_lock_n [*8] ##1 rmw_lock_n) // [RL10]
    else $error("lock not low exactly two bus cycles");
  AST_FLOAT: assert property (modeNormal && busFloat |-> !addrOe && !dataOe && !rwOe) // [RL11]
    else $error("bus driven while float bit set");
  AST_PERIPH: assert property (!modeNormal && rwS |-> dataOe && !rwOe && coreHold) // [RL14]
    else $error("peripheral read not served");
  AST_SYNC: assert property ($rose(syncOut) |-> phaseCnt == PH_RISE) // [RL8]
    else $error("sync rose at wrong quarter");
  AST_HOLD: assert property (stall && modeNormal |=> $stable(addrOut)) // [RL9]
    else $error("address moved during stall");
  AST_CAPT: assert property (carrierEdge |=> rrCapture == $past(rrCount) && rrPend) // [RL16]
    else $error("carrier edge not captured");
  AST_TONE: assert property (!toneEn |-> !tone_square_out) // [RL15]
    else $error("tone out while disabled");
  AST_ROM: assert property (romExternal |-> !selRom) // [RL6]
    else $error("internal rom selected in test mode");
  COV_NMI: cover property (takeNow && nmiPend);
  COV_LOCK: cover property ($rose(rmw_lock_n));
  COV_CAPT: cover property (carrierEdge);
endmodule
`default_nettype wire

//--- verification/ext_bus_model.sv
// far side of the bus pins: slow memory, wired request lines
// assumes the block's clock; request lines carry pull-ups
`default_nettype none
module ext_bus_model
  import bus_ctl_pkg::*;
(
  input wire logic clk,
  input wire logic [15:0] addrOut,
  input wire logic rwOut,
  input wire logic dataOe,
  input wire logic [7:0] dataOut,
  input wire logic reqAOe,
  input wire logic reqBOe,
  input wire logic extB,
  input wire logic slow,
  output logic readyPin,
  output logic [7:0] dataIn,
  output logic maskable_req_a_n,
  output logic maskable_req_b_n
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] churn = 8'h5a; // pattern for a released data bus
  // released bus changes every cycle so no stale value survives
  always @(posedge clk)
    churn <= churn + 8'h3b;
  // memory answers reads with the low address byte
  assign dataIn = dataOe ? dataOut : (rwOut ? addrOut[7:0] : churn);
  // pull-ups: any party pulling holds the line low
  assign maskable_req_a_n = !reqAOe;
  assign maskable_req_b_n = !(reqBOe || extB);
  // slow memory stretches the cycle
  assign readyPin = !slow;
endmodule
`default_nettype wire

//--- verification/test_mcu_bus_interrupt_control.sv
// self-checking bench for the bus and interrupt control shell
// assumes ext_bus_model on the pins; core side driven here
`default_nettype none
module test_mcu_bus_interrupt_control
  import bus_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, nmiPinN = 1;
  logic [7:0] paddr = 0, coreWdata = 0, rrCount = 0, intReadData = 0;
  logic [31:0] pwdata = 0, prdata;
  logic bus_direction_sel = 1, rwIn = 1, outside_rom_select = 0, carrier_edge_in = 0;
  logic [15:0] addrIn = 0, coreAddr = 0, addrOut, intVector, held;
  logic coreRead = 1, coreOpFetch = 0, coreInstrDone = 1, coreIntMask = 1, coreBreak = 0;
  logic coreRmwStart = 0, rrCarry = 0, timerIrq = 0, extB = 0, slow = 0;
  logic pready, pslverr, maskReqAOe, maskReqBOe, rwOut, rwOe, addrOe, dataOe;
  logic busWeakPulldown, port_d_bit1, rmw_lock_n, phaseTick, coreHold, intTake;
  logic setIntMask, readyPin, maskable_req_a_n, maskable_req_b_n;
  logic [7:0] dataOut, dataIn;
  logic [2:0] comm_mode_sel;
  logic [15:0] expq [$]; // expected vectors, oldest first
  logic [15:0] vtab [3] = '{VEC_TIMER, VEC_EXT, VEC_ROWRX};
  int badCount = 0, nTests = 0, tnum = 0, k, n;
  mcu_bus_interrupt_control dut (.clk, .reset, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .nmiPinN, .maskable_req_a_n, .maskable_req_b_n,
    .maskReqAOut(), .maskReqAOe, .maskReqBOut(), .maskReqBOe, .bus_direction_sel,
    .readyPin, .rwIn, .rwOut, .rwOe, .addrIn, .addrOut, .addrOe, .dataIn, .dataOut,
    .dataOe, .busWeakPulldown, .outside_rom_select, .port_d_bit1, .rmw_lock_n,
    .syncOut(), .phi2Out(), .tone_square_out(), .carrier_edge_in, .coreAddr, .coreWdata,
    .coreRead, .coreOpFetch, .coreInstrDone, .coreIntMask, .coreBreak, .coreRmwStart,
    .rrCount, .rrCarry, .timerIrq, .intReadData, .phaseTick, .coreHold, .intTake,
    .intVector, .setIntMask, .extAddr(), .extWrite(), .extWdata(), .selRom(), .selRam(),
    .selIo(), .comm_mode_sel);
  ext_bus_model far (.clk, .addrOut, .rwOut, .dataOe, .dataOut, .reqAOe(maskReqAOe),
    .reqBOe(maskReqBOe), .extB, .slow, .readyPin, .dataIn, .maskable_req_a_n,
    .maskable_req_b_n);
  // 25 MHz clock
  always #20 clk = !clk;
  // -------------------------------------
  // helpers
  // -------------------------------------
  task closeOut;
    $display("compares %0d mismatches %0d", nTests, badCount);
    if (badCount == 0 && nTests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task tmo;
    badCount++;
    closeOut();
  endtask
  // generic value compare
  task chk(input logic [31:0] g, input logic [31:0] e);
    nTests++;
    if (g !== e)
    begin
      badCount++;
      $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
    end
  endtask
  task fin;
    tnum++;
    $display("test %0d done", tnum);
  endtask
  // one apb transfer; read data and error checked at the pready edge
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [31:0] e, input logic ee);
    int j;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    j = 0;
    do
    begin
      @(posedge clk);
      if (++j > 50) tmo();
    end
    while (pready !== 1'b1);
    if (!w) chk(prdata, e);
    chk(pslverr, ee);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // bounded wait until every expected vector was seen
  task waitq;
    for (int j = 0; expq.size() != 0; j++)
    begin
      if (j > 400) tmo();
      @(posedge clk);
      // core side: a taken vector raises the mask
      if (setIntMask === 1'b1) coreIntMask <= 1'b1;
    end
    // spare edge so the next mask change never meets this one
    @(posedge clk);
  endtask
  // random traffic on the core-side inputs, addrIn and the carrier pin
  always @(posedge clk)
  begin
    coreAddr <= 16'($urandom);
    coreWdata <= 8'($urandom);
    rrCount <= 8'($urandom);
    intReadData <= 8'($urandom);
    addrIn <= 16'($urandom);
    coreRead <= 1'($urandom);
    coreOpFetch <= 1'($urandom);
    rrCarry <= 1'($urandom);
    carrier_edge_in <= 1'($urandom);
  end
  // result watcher: every vector taken must be the oldest note
  always @(posedge clk)
    if (intTake === 1'b1)
      if (expq.size() == 0) chk(1'b1, 1'b0);
      else chk(intVector, expq.pop_front());
  // -------------------------------------
  // main sequence
  // -------------------------------------
  initial
  begin
    void'($urandom(32'h2069));
    expq.push_back(VEC_RESET);
    repeat (20) @(posedge clk);
    chk(rwOut, 1'b1);
    reset <= 1'b0;
    repeat (20) @(posedge clk);
    chk(expq.size(), 1);
    waitq();
    apb(0, REG_CTRL, 0, 0, 0);
    apb(0, 8'h0c, 0, 0, 1);
    chk(port_d_bit1, 1'b1);
    fin();
    // nmi edge, then held low
    nmiPinN <= 1'b0;
    expq.push_back(VEC_NMI);
    waitq();
    repeat (40) @(posedge clk);
    nmiPinN <= 1'b1;
    coreBreak <= 1'b1;
    expq.push_back(VEC_BREAK);
    waitq();
    coreBreak <= 1'b0;
    fin();
    // timer, line b, both lines; each taken twice while held
    for (k = 0; k < 3; k++)
    begin
      timerIrq <= k != 1;
      extB <= k != 0;
      repeat (6) @(posedge clk);
      chk(maskReqAOe, k != 1);
      repeat (2)
      begin
        coreIntMask <= 1'b0;
        expq.push_back(vtab[k]);
        waitq();
      end
      timerIrq <= 1'b0;
      extB <= 1'b0;
      repeat (6) @(posedge clk);
    end
    coreIntMask <= 1'b0;
    repeat (16) @(posedge clk);
    coreIntMask <= 1'b1;
    fin();
    // lock for a read-modify-write
    coreRmwStart <= 1'b1;
    @(negedge clk);
    for (k = 0; phaseTick !== 1'b1 && k < 9; k++) @(negedge clk);
    @(posedge clk);
    coreRmwStart <= 1'b0;
    n = 0;
    repeat (20)
    begin
      @(negedge clk);
      if (rmw_lock_n === 1'b0) n++;
    end
    chk(n, 8);
    // ready stall freezes the address
    slow <= 1'b1;
    for (k = 0; coreHold !== 1'b1; k++)
    begin
      if (k > 12) tmo();
      @(posedge clk);
    end
    held = addrOut;
    repeat (6) @(posedge clk);
    chk(addrOut, held);
    slow <= 1'b0;
    repeat (6) @(posedge clk);
    chk(coreHold, 1'b0);
    apb(1, REG_CTRL, 32'h0000_0018, 0, 0);
    apb(0, REG_CTRL, 0, 32'h0000_0018, 0);
    chk(busWeakPulldown, 1'b1);
    chk(addrOe, 1'b0);
    // pulse width mode: random carrier edges capture and pend
    apb(1, REG_CTRL, 32'h0000_000a, 0, 0);
    repeat (12) @(posedge clk);
    chk(comm_mode_sel, MODE_PULSE);
    chk(maskReqBOe, 1'b1);
    fin();
    // reset with direction low: test mode, peripheral access
    bus_direction_sel <= 1'b0;
    rwIn <= 1'b0;
    reset <= 1'b1;
    expq.push_back(VEC_RESET);
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    chk(rwOe, 1'b0);
    chk(addrOe, 1'b0);
    chk(dataOe, 1'b0);
    rwIn <= 1'b1;
    outside_rom_select <= 1'b1;
    repeat (4) @(posedge clk);
    chk(dataOe, 1'b1);
    chk(port_d_bit1, 1'b1);
    outside_rom_select <= 1'b0;
    bus_direction_sel <= 1'b1;
    repeat (4) @(posedge clk);
    chk(port_d_bit1, 1'b0);
    chk(rwOe, 1'b1);
    waitq();
    apb(0, REG_STAT, 0, 32'h0000_0004, 0);
    apb(0, REG_CTRL, 0, 0, 0);
    chk(busWeakPulldown, 1'b0);
    fin();
    closeOut();
  end
endmodule
`default_nettype wire
